// [rtl/ibti_map.v]
// combinational level to symbol mapping for one input
`timescale 1ns/1ps
`include "ibti_defs.vh"

module ibti_map (
  // selection
  input  wire       is_addr_i,
  input  wire       data_strap_i,
  input  wire [1:0] addr_strap_i,
  // level in, symbol out
  input  wire       level_i,
  output reg  [1:0] sym_o
);

  always @* begin
    sym_o = `IBTI_SYM_ZERO;
    if (level_i) begin
      sym_o = `IBTI_SYM_ONE;
      if (is_addr_i && addr_strap_i == `IBTI_ACFG_10) begin
        sym_o = `IBTI_SYM_OPEN;
      end
    end else if (is_addr_i) begin
      if (addr_strap_i == `IBTI_ACFG_01) begin
        sym_o = `IBTI_SYM_OPEN;
      end
    end else if (!data_strap_i) begin
      sym_o = `IBTI_SYM_OPEN;
    end
  end

endmodule // ibti_map

// [rtl/ibti_top.v]
// input bit type interpreter and word sequencer in front of the encoder
`timescale 1ns/1ps
`include "ibti_defs.vh"

module ibti_top #(
  parameter ADDR_BITS = `IBTI_ADDR_BITS,
  parameter DATA_BITS = `IBTI_DATA_BITS,
  parameter WORDS     = `IBTI_WORDS,
  parameter SYM_NS    = `IBTI_SYM_NS
) (
  // clock and reset
  input  wire                 clk_sys_i,
  input  wire                 resetn_i,
  // pins: levels and pin enables (enable low means left unconnected)
  input  wire [ADDR_BITS-1:0] address_inputs_i,
  input  wire [ADDR_BITS-1:0] address_inputs_en_i,
  input  wire [DATA_BITS-1:0] data_inputs_i,
  input  wire [DATA_BITS-1:0] data_inputs_en_i,
  input  wire                 transmit_trigger_i,
  // straps: level and driven flag
  input  wire                 data_interp_strap_i,
  input  wire                 data_interp_strap_en_i,
  input  wire                 addr_interp_strap_low_i,
  input  wire                 addr_interp_strap_low_en_i,
  input  wire                 addr_interp_strap_high_i,
  input  wire                 addr_interp_strap_high_en_i,
  // to serial encoder
  output reg  [1:0]           sym_o,
  output reg                  sym_valid_o,
  output reg                  word_start_o,
  output reg                  busy_o
);

  localparam integer SYM_CYC_RAW = (`IBTI_CLK_HZ / `IBTI_HZ_PER_MHZ) * SYM_NS
                                   / `IBTI_NS_PER_US;
  localparam integer SYM_CYC     = (SYM_CYC_RAW < 1) ? 1 : SYM_CYC_RAW;
  localparam integer WORD_LEN    = ADDR_BITS + DATA_BITS;
  localparam integer NIN         = WORD_LEN;

  // last values of the sequencer counters, cut to the counter widths
  localparam integer TICK_LAST_I = SYM_CYC - 1;
  localparam integer BIT_LAST_I  = WORD_LEN - 1;
  localparam integer WORD_LAST_I = WORDS - 1;
  localparam [15:0]  TICK_LAST   = TICK_LAST_I[15:0];
  localparam [7:0]   BIT_LAST    = BIT_LAST_I[7:0];
  localparam [3:0]   WORD_LAST   = WORD_LAST_I[3:0];

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SEND = 3'b010;
  localparam [2:0] ST_LOAD = 3'b100;

  // ==========================================================
  // reset release
  // asserted at once, released in step with the clock
  reg rst_s1;
  reg rst_n;
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  // ==========================================================
  // weak pulls on pins and straps
  // an open pin reads as the level of its internal pull
  function pin_level;
    input lvl;
    input driven;
    input pull_high;
    begin
      pin_level = driven ? lvl : pull_high;
    end
  endfunction

  wire [ADDR_BITS-1:0] addr_pin;
  wire [DATA_BITS-1:0] data_pin;
  genvar gp;
  generate
    for (gp = 0; gp < ADDR_BITS; gp = gp + 1) begin : g_apull
      assign addr_pin[gp] = pin_level(address_inputs_i[gp], address_inputs_en_i[gp], `IBTI_PULL_UP);
    end
    for (gp = 0; gp < DATA_BITS; gp = gp + 1) begin : g_dpull
      assign data_pin[gp] = pin_level(data_inputs_i[gp], data_inputs_en_i[gp], `IBTI_PULL_DOWN);
    end
  endgenerate
  wire d_strap_pin = pin_level(data_interp_strap_i, data_interp_strap_en_i, `IBTI_PULL_DOWN);
  wire a_lo_pin    = pin_level(addr_interp_strap_low_i, addr_interp_strap_low_en_i, `IBTI_PULL_DOWN);
  wire a_hi_pin    = pin_level(addr_interp_strap_high_i, addr_interp_strap_high_en_i, `IBTI_PULL_UP);

  // ==========================================================
  // two-stage synchronisers
  // straps share the flops with the pins so one load sees one coherent set
  localparam integer SW = NIN + 4;
  wire [SW-1:0] raw_in = {transmit_trigger_i,
                          a_hi_pin,
                          a_lo_pin,
                          d_strap_pin,
                          data_pin,
                          addr_pin};
  reg  [SW-1:0] sync1;
  reg  [SW-1:0] sync2;
  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= {SW{1'b0}};
      sync2 <= {SW{1'b0}};
    end else begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end
  wire                 trig_s   = sync2[SW-1];
  wire [1:0]           astrap_s = sync2[SW-2:SW-3];
  wire                 dstrap_s = sync2[SW-4];
  wire [NIN-1:0]       lvl_s    = sync2[NIN-1:0];

  // ==========================================================
  // per-input symbol mapping
  wire [2*NIN-1:0] sym_all;
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_map
      ibti_map u_map (
        .is_addr_i    (gi < ADDR_BITS),
        .data_strap_i (dstrap_s),
        .addr_strap_i (astrap_s),
        .level_i      (lvl_s[gi]),
        .sym_o        (sym_all[2*gi+1:2*gi])
      );
    end
  endgenerate

  // ==========================================================
  // sequencer
  reg [2:0]           state;
  reg [2*NIN-1:0]     snap;
  reg [15:0]          tick_cnt;
  reg [7:0]           bit_idx;
  reg [3:0]           word_idx;
  // with a one-cycle symbol the counter never leaves zero
  wire                tick = (tick_cnt == TICK_LAST);

  always @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state        <= ST_IDLE;
      snap         <= {2*NIN{1'b0}};
      tick_cnt     <= 16'h0000;
      bit_idx      <= 8'h00;
      word_idx     <= 4'h0;
      sym_o        <= `IBTI_SYM_ZERO;
      sym_valid_o  <= 1'b0;
      word_start_o <= 1'b0;
      busy_o       <= 1'b0;
    end else begin
      sym_valid_o  <= 1'b0;
      word_start_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          // busy drops one cycle after the last symbol
          busy_o <= 1'b0;
          if (trig_s) begin
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          // pin changes after this point wait for the next load
          snap     <= sym_all;
          tick_cnt <= 16'h0000;
          bit_idx  <= 8'h00;
          word_idx <= 4'h0;
          busy_o   <= 1'b1;
          state    <= ST_SEND;
        end
        ST_SEND: begin
          if (tick) begin
            tick_cnt    <= 16'h0000;
            sym_o       <= snap[2*bit_idx +: 2];
            sym_valid_o <= 1'b1;
            word_start_o <= (bit_idx == 8'h00);
            if (bit_idx == BIT_LAST) begin
              bit_idx <= 8'h00;
              if (word_idx == WORD_LAST) begin
                word_idx <= 4'h0;
                // a trigger that falls mid-cycle still lets the third word out
                state    <= trig_s ? ST_LOAD : ST_IDLE;
              end else begin
                word_idx <= word_idx + 4'h1;
              end
            end else begin
              bit_idx <= bit_idx + 8'h01;
            end
          end else begin
            tick_cnt <= tick_cnt + 16'h0001;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // ibti_top

// [shared/ibti_defs.vh]
// constants for the input bit type interpreter
`ifndef IBTI_DEFS_VH
`define IBTI_DEFS_VH

// symbol codes handed to the encoder
`define IBTI_SYM_ZERO   2'h0
`define IBTI_SYM_ONE    2'h1
`define IBTI_SYM_OPEN   2'h2
`define IBTI_SYM_W      2

// address strap encodings {high, low}
`define IBTI_ACFG_00    2'h0
`define IBTI_ACFG_01    2'h1
`define IBTI_ACFG_10    2'h2
`define IBTI_ACFG_11    2'h3

// word layout
`define IBTI_ADDR_BITS  10
`define IBTI_DATA_BITS  8
`define IBTI_WORDS      3

// timing: one symbol period and cycle lag bound
`define IBTI_CLK_HZ     50000000
`define IBTI_SYM_NS     1000
`define IBTI_LAG_MS     150
`define IBTI_HZ_PER_MHZ 1000000
`define IBTI_NS_PER_US  1000

// levels of the internal weak pulls
`define IBTI_PULL_UP    1'h1
`define IBTI_PULL_DOWN  1'h0

`endif

// [testbench/ibti_assertions.sv]
// checker on the interpreter's encoder-side outputs
`timescale 1ns/1ps
module ibti_assertions (
  input wire       clk_sys_i,
  input wire       resetn_i,
  input wire       transmit_trigger_i,
  input wire       data_interp_strap_i,
  input wire       data_interp_strap_en_i,
  input wire       addr_interp_strap_low_i,
  input wire       addr_interp_strap_low_en_i,
  input wire       addr_interp_strap_high_i,
  input wire       addr_interp_strap_high_en_i,
  input wire [1:0] sym_o,
  input wire       sym_valid_o,
  input wire       word_start_o,
  input wire       busy_o
);
  // ====
  // properties
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  a_valid_busy: assert property (sym_valid_o |-> busy_o) else $error("symbol while idle");
  a_start_valid: assert property (word_start_o |-> sym_valid_o) else $error("start without symbol");
  a_sym_code: assert property (sym_valid_o |-> sym_o != 2'h3) else $error("bad symbol code");
  a_start_gap: assert property (word_start_o |=> !word_start_o [*8]) else $error("word too short");
  a_busy_min: assert property ($rose(busy_o) |=> busy_o [*8]) else $error("cycle cut short");
  a_trig_load: assert property ($rose(transmit_trigger_i) && !busy_o |-> ##[1:8] busy_o)
    else $error("trigger not taken");
  a_first_sym: assert property ($rose(busy_o) |-> ##[1:60] (sym_valid_o && word_start_o))
    else $error("no first symbol");
  a_no_open: assert property (sym_valid_o && data_interp_strap_en_i && data_interp_strap_i
    && addr_interp_strap_low_en_i && addr_interp_strap_high_en_i
    && addr_interp_strap_low_i == addr_interp_strap_high_i |-> sym_o != 2'h2)
    else $error("open symbol in one-zero mapping");
endmodule // ibti_assertions

bind ibti_top ibti_assertions u_chk (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
  .transmit_trigger_i(transmit_trigger_i), .data_interp_strap_i(data_interp_strap_i),
  .data_interp_strap_en_i(data_interp_strap_en_i), .addr_interp_strap_low_i(addr_interp_strap_low_i),
  .addr_interp_strap_low_en_i(addr_interp_strap_low_en_i), .addr_interp_strap_high_i(addr_interp_strap_high_i),
  .addr_interp_strap_high_en_i(addr_interp_strap_high_en_i), .sym_o(sym_o), .sym_valid_o(sym_valid_o),
  .word_start_o(word_start_o), .busy_o(busy_o));

// [testbench/ibti_pins.sv]
// buttons, dip switches and trigger diodes
`timescale 1ns/1ps
module ibti_pins (
  // switch settings
  input  wire [9:0] dip_i,
  input  wire [9:0] aen_i,
  input  wire [7:0] press_i,
  input  wire [7:0] den_i,
  // pin levels
  output wire [9:0] addr_o,
  output wire [7:0] data_o,
  output wire       trig_o
);
  // an open pin shows the opposite of its pull
  assign addr_o = dip_i & aen_i;
  assign data_o = press_i | ~den_i;
  assign trig_o = |(press_i & den_i);
endmodule // ibti_pins

// [testbench/testbench.sv]
// self-checking bench for the interpreter
`timescale 1ns/1ps
`include "ibti_defs.vh"
module testbench;
  reg         clk_sys_i = 1'b0;
  reg         resetn_i = 1'b0;
  reg  [9:0]  dip = 10'h001;
  reg  [9:0]  aen = 10'h3ff;
  reg  [7:0]  press = 8'h00;
  reg  [7:0]  den = 8'hff;
  reg  [5:0]  strap = 6'h00;
  reg  [31:0] rs = 32'd16013;
  reg  [1:0]  exp_sym [0:35];
  reg  [35:0] exp_lvl;
  reg  [7:0]  q;
  wire [9:0]  al;
  wire [7:0]  dl;
  wire [1:0]  sym;
  wire        trg, vld, ws, busy;
  integer     err_total = 0, checks = 0, n = 0, k, t, r, e;
  ibti_top #(.SYM_NS(20)) dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .address_inputs_i(al),
    .address_inputs_en_i(aen), .data_inputs_i(dl), .data_inputs_en_i(den), .transmit_trigger_i(trg),
    .data_interp_strap_i(strap[4]), .data_interp_strap_en_i(strap[5]), .addr_interp_strap_low_i(strap[2]),
    .addr_interp_strap_low_en_i(strap[3]), .addr_interp_strap_high_i(strap[0]),
    .addr_interp_strap_high_en_i(strap[1]), .sym_o(sym), .sym_valid_o(vld), .word_start_o(ws), .busy_o(busy));
  ibti_pins u_pins (.dip_i(dip), .aen_i(aen), .press_i(press), .den_i(den), .addr_o(al), .data_o(dl), .trig_o(trg));
  // ====
  // model and checks
  function [31:0] xs(input [31:0] s);
    reg [31:0] v;
    begin
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      xs = v ^ (v << 5);
    end
  endfunction
  function [1:0] map(input a, input lvl, input en);
    reg l, h, lo;
    begin
      l = en ? lvl : a;
      h = strap[1] ? strap[0] : 1'b1;
      lo = strap[3] ? strap[2] : 1'b0;
      if (!a) map = l ? `IBTI_SYM_ONE : ((strap[5] & strap[4]) ? `IBTI_SYM_ZERO : `IBTI_SYM_OPEN);
      else if ({h, lo} == 2'b01) map = l ? `IBTI_SYM_ONE : `IBTI_SYM_OPEN;
      else if ({h, lo} == 2'b10) map = l ? `IBTI_SYM_OPEN : `IBTI_SYM_ZERO;
      else map = l ? `IBTI_SYM_ONE : `IBTI_SYM_ZERO;
    end
  endfunction
  task cmp(input [8*6:1] nm, input [7:0] e, input [7:0] s);
    begin
      checks = checks + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("MISMATCH %0s expected %0h seen %0h", nm, e, s);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge clk_sys_i) if (vld === 1'b1) begin
    e = (n >= 54 ? 18 : 0) + n % 18;
    cmp("symbol", exp_sym[e], sym);
    cmp("start", n % 18 == 0, ws);
    if (n % 18 >= 10) cmp("decode", exp_lvl[e], sym == `IBTI_SYM_ONE);
    n = n + 1;
  end
  // press, switch buttons mid-cycle, release and count symbols
  task run(input [7:0] p, input [7:0] p2, input integer hold, input integer cyc);
    begin
      for (t = 0; t < 36; t = t + 1) begin
        r = t % 18;
        q = t < 18 ? p : p2;
        exp_lvl[t] = 1'b0;
        if (r < 10) exp_sym[t] = map(1'b1, dip[r], aen[r]);
        else begin
          exp_sym[t] = map(1'b0, q[r - 10], den[r - 10]);
          exp_lvl[t] = q[r - 10] & den[r - 10];
        end
      end
      n = 0;
      press = p;
      for (t = 0; t < 20 && busy !== 1'b1; t = t + 1) @(negedge clk_sys_i);
      repeat (hold) @(negedge clk_sys_i);
      press = p2;
      repeat (hold) @(negedge clk_sys_i);
      press = 8'h00;
      for (t = 0; t < 400 && busy !== 1'b0; t = t + 1) @(negedge clk_sys_i);
      cmp("count", 54 * cyc, n);
    end
  endtask
  initial forever #10 clk_sys_i = ~clk_sys_i;
  initial begin
    #400000;
    err_total = err_total + 1;
    print_verdict;
  end
  initial begin
    repeat (12) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    repeat (4) @(negedge clk_sys_i);
    for (k = 0; k < 30; k = k + 1) begin
      rs = xs(rs);
      strap = k == 0 ? 6'h00 : k == 1 ? 6'h3f : k == 2 ? 6'h0e : k == 3 ? 6'h3a : rs[5:0];
      dip = rs[15:6];
      dip[1] = ~dip[0];
      aen = rs[25:16] | 10'h003;
      den = rs[31:24] | 8'h01;
      run(rs[23:16] | 8'h01, k == 5 ? ~rs[23:16] | 8'h01 : rs[23:16] | 8'h01,
        k == 5 ? 35 : 2, k == 5 ? 2 : 1);
    end
    print_verdict;
  end
endmodule // testbench
